// *** pkg/mode_reset_pkg.sv ***
package mode_reset_pkg;

   // clock
   localparam int CLK_HZ = 20000000;
   localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;

   // times in their own units, then cycle counts (least times round up)
   localparam int WAKE_PULSE_NS = 10000;
   localparam int WAKE_CYCLES = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEBOUNCE_NS = 16000000;
   localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CPU_DELAY_CYCLES = 32768;
   localparam int SYS_DELAY_CYCLES = 16;

   // register byte offsets
   localparam logic [7:0] SYS_CONTROL_ONE_OFS = 8'h00;
   localparam logic [7:0] SYS_CONTROL_TWO_OFS = 8'h04;
   localparam logic [7:0] PORT_RESET_SELECT_A_OFS = 8'h08;
   localparam logic [7:0] PORT_RESET_SELECT_B_OFS = 8'h0c;
   localparam logic [7:0] PORT_RESET_SLEEP_OPTION_OFS = 8'h10;
   localparam logic [7:0] LEVEL_DETECT_CONTROL_OFS = 8'h14;
   localparam logic [7:0] DISPLAY_CONTROL_ONE_OFS = 8'h18;
   localparam logic [7:0] STATUS_OFS = 8'h1c;

   // field positions
   localparam int SLEEP_BIT = 0;
   localparam int SLEEP_ARM_BIT = 2;
   localparam int IN_SLEEP_BIT = 0;
   localparam int OSC_GUARD_OFF_BIT = 0;
   localparam int STROBE_SEL_LSB = 0;
   localparam int STATUS_MODE_LSB = 0;
   localparam int STATUS_INHIBIT_BIT = 2;
   localparam int STATUS_CAUSE_LSB = 3;

   // reset values
   localparam logic SLEEP_ARM_RST = 1'b0;
   localparam logic [3:0] SELECT_RST = 4'h0;
   localparam logic IN_SLEEP_RST = 1'b0;
   localparam logic OSC_GUARD_OFF_RST = 1'b0;
   localparam logic [1:0] STROBE_SEL_RST = 2'h0;

   // reset cause vector positions
   localparam int CAUSE_PIN = 0;
   localparam int CAUSE_PORT = 1;
   localparam int CAUSE_WDOG = 2;
   localparam int CAUSE_OSC = 3;
   localparam int CAUSE_SLEEP = 4;
   localparam int CAUSE_W = 5;

   typedef enum logic [1:0] {MODE_ACTIVE, MODE_STANDBY, MODE_SLEEP} mode_t;

endpackage

// *** rtl/mode_and_reset_control.sv ***
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
module mode_and_reset_control #(
   parameter int CPU_DELAY = mode_reset_pkg::CPU_DELAY_CYCLES,
   parameter int DEBOUNCE = mode_reset_pkg::DEBOUNCE_CYCLES,
   parameter int SYS_DELAY = mode_reset_pkg::SYS_DELAY_CYCLES,
   parameter int WAKE_FILTER = mode_reset_pkg::WAKE_CYCLES
) (
   // clock and power-on reset
   input wire logic clock_in,
   input wire logic srst_in,
   // ahb-lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // cpu side
   input wire logic halt_in,
   input wire logic irq_pending_in,
   input wire logic watchdog_reset_in,
   output logic cpu_clock_enable_out,
   output logic cpu_reset_out,
   output logic sys_reset_out,
   // pins and oscillator
   input wire logic reset_pin_in,
   input wire logic [3:0] input_port_pin_in,
   input wire logic osc_stopped_in,
   input wire logic strobe_alt_in,
   output logic osc_enable_out,
   output logic strobe_out,
   // peripheral control
   input wire logic level_detect_busy_in,
   output logic periph_clock_enable_out,
   output logic level_detect_enable_out,
   output logic port_b_hiz_out,
   output logic serial_hiz_out,
   output logic buzzer_hiz_out,
   output logic input_port_enable_out,
   output logic [1:0] mode_out
);
   import mode_reset_pkg::*;

   localparam int SW = $clog2(SYS_DELAY + 1);
   localparam int CW = $clog2(CPU_DELAY + 1);
   localparam int DW = $clog2(DEBOUNCE + 1);
   localparam int WW = $clog2(WAKE_FILTER + 1);

   // one selected port A term
   function automatic logic port_reset_term(input logic sa, input logic sb, input logic pin);
      logic t;
      t = 1'b0;
      case ({sa, sb})
         2'b00: t = 1'b0;
         2'b01: t = pin;
         2'b10: t = ~pin;
         2'b11: t = 1'b1;
         default: t = 1'b0;
      endcase
      return t;
   endfunction

   mode_t mode_r;

   // synchronisers
   logic pin_meta_r, pin_sync_r;
   logic [3:0] port_meta_r, port_sync_r;
   logic osc_meta_r, osc_sync_r;

   // registers
   logic sleep_arm_r;
   logic [3:0] sel_a_r, sel_b_r;
   logic port_reset_in_sleep_r;
   logic osc_guard_off_r;
   logic [1:0] strobe_source_sel_r;
   logic [CAUSE_W-1:0] cause_r;

   // reset stretching
   logic [SW-1:0] sys_cnt_r;
   logic [CW-1:0] cpu_cnt_r;
   logic wake_inhibit_r;

   // filters
   logic [DW-1:0] deb_cnt_r [2];
   logic [WW-1:0] wake_cnt_r;
   logic [1:0] deb_raw;
   logic [1:0] deb_hit;

   // bus
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] hrdata_r;

   logic level_detect_run_r;
   logic strobe_r;

   logic [3:0] term;
   logic combo;
   logic sleeping;
   logic wake;
   logic osc_loss;
   logic sleep_req;
   logic [CAUSE_W-1:0] src_vec;
   logic any_src;
   logic run_src;
   logic bus_take;

   assign sleeping = (mode_r == MODE_SLEEP);

   // two flops before any logic reads pins
   always_ff @(posedge clock_in) begin
      pin_meta_r <= reset_pin_in;
      pin_sync_r <= pin_meta_r;
      port_meta_r <= input_port_pin_in;
      port_sync_r <= port_meta_r;
      osc_meta_r <= osc_stopped_in;
      osc_sync_r <= osc_meta_r;
   end

   // port A combination
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         term[i] = port_reset_term(sel_a_r[i], sel_b_r[i], port_sync_r[i]);
      end
   end

   // all-high selection gives a constant true, held as reset through the debouncer
   assign combo = &term;

   // debouncers, idle in sleep because there is no clock there in the real part
   assign deb_raw = {combo, pin_sync_r};

   always_ff @(posedge clock_in) begin
      for (int i = 0; i < 2; i++) begin
         if (srst_in || sleeping || !deb_raw[i]) begin
            deb_cnt_r[i] <= '0;
         end else if (deb_cnt_r[i] != DW'(DEBOUNCE)) begin
            deb_cnt_r[i] <= deb_cnt_r[i] + DW'(1);
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         deb_hit[i] = (deb_cnt_r[i] == DW'(DEBOUNCE));
      end
   end

   // wake filter stands in for the analogue filter on the reset pin
   always_ff @(posedge clock_in) begin
      if (srst_in || !sleeping || !pin_sync_r) begin
         wake_cnt_r <= '0;
      end else if (wake_cnt_r != WW'(WAKE_FILTER)) begin
         wake_cnt_r <= wake_cnt_r + WW'(1);
      end
   end

   assign wake = sleeping && ((wake_cnt_r == WW'(WAKE_FILTER)) ||
                              (port_reset_in_sleep_r && combo));

   assign osc_loss = !sleeping && osc_sync_r && !osc_guard_off_r &&
                     !wake_inhibit_r;

   always_comb begin
      src_vec = '0;
      src_vec[CAUSE_PIN] = deb_hit[0];
      src_vec[CAUSE_PORT] = deb_hit[1];
      src_vec[CAUSE_WDOG] = watchdog_reset_in && !sleeping;
      src_vec[CAUSE_OSC] = osc_loss;
      src_vec[CAUSE_SLEEP] = sleeping;
   end

   assign any_src = |src_vec;
   assign run_src = |src_vec[CAUSE_OSC:CAUSE_PIN];

   // system and cpu reset stretchers; power-on loads both
   always_ff @(posedge clock_in) begin
      if (srst_in || any_src) begin
         sys_cnt_r <= SW'(SYS_DELAY);
      end else if (sys_cnt_r != '0) begin
         sys_cnt_r <= sys_cnt_r - SW'(1);
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in || any_src) begin
         cpu_cnt_r <= CW'(CPU_DELAY);
      end else if (cpu_cnt_r != '0) begin
         cpu_cnt_r <= cpu_cnt_r - CW'(1);
      end
   end

   // loss detection would fire on the cold-start oscillator, so hold it off
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         wake_inhibit_r <= 1'b0;
      end else if (wake) begin
         wake_inhibit_r <= 1'b1;
      end else if (cpu_cnt_r == '0) begin
         wake_inhibit_r <= 1'b0;
      end
   end

   assign sys_reset_out = (sys_cnt_r != '0);
   assign cpu_reset_out = (cpu_cnt_r != '0);

   // mode machine; a reset beats a sleep write in the same cycle
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         mode_r <= MODE_ACTIVE;
      end else begin
         case (mode_r)
            MODE_SLEEP: begin
               if (wake) begin
                  mode_r <= MODE_ACTIVE;
               end
            end
            MODE_ACTIVE: begin
               if (run_src) begin
                  mode_r <= MODE_ACTIVE;
               end else if (sleep_req) begin
                  mode_r <= MODE_SLEEP;
               end else if (halt_in && !cpu_reset_out) begin
                  mode_r <= MODE_STANDBY;
               end
            end
            MODE_STANDBY: begin
               if (run_src || irq_pending_in) begin
                  mode_r <= MODE_ACTIVE;
               end else if (sleep_req) begin
                  mode_r <= MODE_SLEEP;
               end
            end
            default: mode_r <= MODE_ACTIVE;
         endcase
      end
   end

   assign mode_out = mode_r;
   assign cpu_clock_enable_out = (mode_r == MODE_ACTIVE) && !cpu_reset_out;
   assign periph_clock_enable_out = !sleeping;
   assign osc_enable_out = !sleeping;
   assign port_b_hiz_out = sleeping;
   assign serial_hiz_out = sleeping;
   assign buzzer_hiz_out = sleeping;
   assign input_port_enable_out = !sleeping || port_reset_in_sleep_r;

   // detector keeps running in standby only until its measure ends
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         level_detect_run_r <= 1'b0;
      end else begin
         level_detect_run_r <= (mode_r == MODE_ACTIVE) ||
            ((mode_r == MODE_STANDBY) && level_detect_run_r && level_detect_busy_in);
      end
   end

   assign level_detect_enable_out = level_detect_run_r;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         strobe_r <= 1'b1;
      end else if (strobe_source_sel_r == 2'h0) begin
         strobe_r <= cpu_reset_out;
      end else begin
         strobe_r <= strobe_alt_in;
      end
   end

   assign strobe_out = strobe_r;

   // ahb-lite: zero wait states, always okay
   assign bus_take = hsel_in && htrans_in[1] && hready_in;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= bus_take && hwrite_in;
         if (bus_take) begin
            wr_addr_r <= haddr_in[7:0];
         end
      end
   end

   assign sleep_req = wr_pend_r && (wr_addr_r == SYS_CONTROL_ONE_OFS) &&
                      hwdata_in[SLEEP_BIT] && sleep_arm_r;

   // option registers and sleep_arm survive every reset except power-on
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         sleep_arm_r <= SLEEP_ARM_RST;
         sel_a_r <= SELECT_RST;
         sel_b_r <= SELECT_RST;
         port_reset_in_sleep_r <= IN_SLEEP_RST;
      end else if (wr_pend_r) begin
         case (wr_addr_r)
            SYS_CONTROL_TWO_OFS: sleep_arm_r <= hwdata_in[SLEEP_ARM_BIT];
            PORT_RESET_SELECT_A_OFS: sel_a_r <= hwdata_in[3:0];
            PORT_RESET_SELECT_B_OFS: sel_b_r <= hwdata_in[3:0];
            PORT_RESET_SLEEP_OPTION_OFS: port_reset_in_sleep_r <= hwdata_in[IN_SLEEP_BIT];
            default: ;
         endcase
      end
   end

   // ordinary registers follow the system reset as well
   always_ff @(posedge clock_in) begin
      if (srst_in || sys_reset_out) begin
         osc_guard_off_r <= OSC_GUARD_OFF_RST;
         strobe_source_sel_r <= STROBE_SEL_RST;
      end else if (wr_pend_r) begin
         case (wr_addr_r)
            LEVEL_DETECT_CONTROL_OFS: osc_guard_off_r <= hwdata_in[OSC_GUARD_OFF_BIT];
            DISPLAY_CONTROL_ONE_OFS:
               strobe_source_sel_r <= hwdata_in[STROBE_SEL_LSB +: 2];
            default: ;
         endcase
      end
   end

   // last reset cause; power-on clears it
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         cause_r <= '0;
      end else if (any_src) begin
         cause_r <= src_vec;
      end
   end

   // read data prepared in the address phase
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         hrdata_r <= 32'h0000_0000;
      end else if (bus_take && !hwrite_in) begin
         hrdata_r <= 32'h0000_0000;
         case (haddr_in[7:0])
            SYS_CONTROL_ONE_OFS: hrdata_r[SLEEP_BIT] <= sleeping;
            SYS_CONTROL_TWO_OFS: hrdata_r[SLEEP_ARM_BIT] <= sleep_arm_r;
            PORT_RESET_SELECT_A_OFS: hrdata_r[3:0] <= sel_a_r;
            PORT_RESET_SELECT_B_OFS: hrdata_r[3:0] <= sel_b_r;
            PORT_RESET_SLEEP_OPTION_OFS: hrdata_r[IN_SLEEP_BIT] <= port_reset_in_sleep_r;
            LEVEL_DETECT_CONTROL_OFS: hrdata_r[OSC_GUARD_OFF_BIT] <= osc_guard_off_r;
            DISPLAY_CONTROL_ONE_OFS: hrdata_r[STROBE_SEL_LSB +: 2] <= strobe_source_sel_r;
            STATUS_OFS: begin
               hrdata_r[STATUS_MODE_LSB +: 2] <= mode_r;
               hrdata_r[STATUS_INHIBIT_BIT] <= wake_inhibit_r;
               hrdata_r[STATUS_CAUSE_LSB +: CAUSE_W] <= cause_r;
            end
            default: ;
         endcase
      end
   end

   assign hrdata_out = hrdata_r;
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;

endmodule

// *** tb/mode_and_reset_control_test.sv ***
`timescale 1ns/100ps
module mode_and_reset_control_test;
   import mode_reset_pkg::*;
   localparam int CPU_D = 40;
   localparam int DEB = 20;
   localparam int SYS_D = 4;
   localparam int WAKE_F = 5;
   localparam int LIMIT = 5000;
   typedef struct packed {
      logic [3:0] sel_a;
      logic [3:0] sel_b;
      logic [3:0] pins;
      logic hit;
   } combo_row_t;
   combo_row_t rows [8] = '{'{4'h0, 4'h0, 4'hf, 1'b0}, '{4'h0, 4'hf, 4'hf, 1'b1},
      '{4'h0, 4'hf, 4'h7, 1'b0}, '{4'hf, 4'h0, 4'h0, 1'b1}, '{4'hf, 4'h0, 4'h1, 1'b0},
      '{4'h5, 4'ha, 4'ha, 1'b1}, '{4'h5, 4'ha, 4'hb, 1'b0}, '{4'hf, 4'hf, 4'h0, 1'b1}};
   logic clock_in;
   logic srst_in = 1'b1;
   logic hsel = 1'b0, hwrite = 1'b0, halt = 1'b0, irq = 1'b0, wdog = 1'b0, osc_stop = 1'b0;
   logic busy = 1'b0, strobe_alt = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'b00, mode;
   logic hready, hresp, cpu_en, cpu_rst, sys_rst, osc_en, strobe, pclk_en, lvl_en;
   logic pb_hiz, sp_hiz, bz_hiz, pa_en, pin;
   logic [3:0] port;
   int miscompares = 0, tests_run = 0, cycles = 0;

   pin_side_model i_far (.clock_in(clock_in), .reset_pin_out(pin), .input_port_pin_out(port));
   mode_and_reset_control #(.CPU_DELAY(CPU_D), .DEBOUNCE(DEB), .SYS_DELAY(SYS_D),
      .WAKE_FILTER(WAKE_F)) i_dut (
      .clock_in(clock_in), .srst_in(srst_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata),
      .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
      .halt_in(halt), .irq_pending_in(irq), .watchdog_reset_in(wdog),
      .cpu_clock_enable_out(cpu_en), .cpu_reset_out(cpu_rst), .sys_reset_out(sys_rst),
      .reset_pin_in(pin), .input_port_pin_in(port), .osc_stopped_in(osc_stop),
      .strobe_alt_in(strobe_alt), .osc_enable_out(osc_en), .strobe_out(strobe),
      .level_detect_busy_in(busy), .periph_clock_enable_out(pclk_en),
      .level_detect_enable_out(lvl_en), .port_b_hiz_out(pb_hiz), .serial_hiz_out(sp_hiz),
      .buzzer_hiz_out(bz_hiz), .input_port_enable_out(pa_en), .mode_out(mode)
   );

   initial begin
      clock_in = 1'b0;
      forever #25 clock_in = ~clock_in;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         stop_test();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // settle past the edge before sampling
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge clock_in);
      while (hready !== 1'b1) @(posedge clock_in);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clock_in);
      while (hready !== 1'b1) @(posedge clock_in);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(name, rd, exp);
   endtask

   task automatic wait_rst();
      int n = 0;
      while (cpu_rst !== 1'b0 && n < 400) begin
         tick(1);
         n++;
      end
      chk("cpu reset end", cpu_rst, 0);
   endtask

   initial begin
      tick(20);
      chk("sys reset at power-on", sys_rst, 1);
      chk("cpu reset at power-on", cpu_rst, 1);
      chk("strobe in reset", strobe, 1);
      srst_in <= 1'b0;
      wait_rst();
      tick(2);
      chk("strobe after reset", strobe, 0);
      chk("cpu clock enable", cpu_en, 1);
      chk("bus response okay", hresp, 0);
      rdchk("arm at power-on", SYS_CONTROL_TWO_OFS, 32'h0);
      rdchk("unmapped read", 8'h40, 32'h0);
      foreach (rows[i]) begin
         i_far.set_port(rows[i].pins);
         wr(PORT_RESET_SELECT_A_OFS, {28'h0, rows[i].sel_a});
         wr(PORT_RESET_SELECT_B_OFS, {28'h0, rows[i].sel_b});
         tick(DEB + 8);
         chk("port combination reset", sys_rst, rows[i].hit);
         i_far.set_port(4'h0);
         wr(PORT_RESET_SELECT_A_OFS, 32'h0);
         wr(PORT_RESET_SELECT_B_OFS, 32'h0);
         wait_rst();
      end
      busy <= 1'b1;
      halt <= 1'b1;
      tick(1);
      halt <= 1'b0;
      tick(1);
      chk("standby", mode, MODE_STANDBY);
      chk("cpu clock in standby", cpu_en, 0);
      chk("level detect measure runs on", lvl_en, 1);
      busy <= 1'b0;
      tick(2);
      chk("level detect stops in standby", lvl_en, 0);
      irq <= 1'b1;
      tick(1);
      irq <= 1'b0;
      tick(1);
      chk("interrupt wake", mode, MODE_ACTIVE);
      wr(SYS_CONTROL_ONE_OFS, 32'h1);
      tick(3);
      chk("sleep unarmed", mode, MODE_ACTIVE);
      wr(SYS_CONTROL_TWO_OFS, 32'h4);
      rdchk("arm set", SYS_CONTROL_TWO_OFS, 32'h4);
      wr(SYS_CONTROL_ONE_OFS, 32'h1);
      tick(3);
      chk("sleep", mode, MODE_SLEEP);
      chk("sleep outputs", {sys_rst, cpu_rst, pb_hiz, sp_hiz, bz_hiz, osc_en, pclk_en, pa_en,
         lvl_en}, 9'h1f0);
      chk("strobe in sleep", strobe, 1);
      i_far.pulse_pin(WAKE_F - 2);
      tick(6);
      chk("short wake pulse", mode, MODE_SLEEP);
      i_far.pulse_pin(WAKE_F + 3);
      tick(4);
      chk("pin wake", mode, MODE_ACTIVE);
      chk("cpu delay after wake", cpu_rst, 1);
      rdchk("arm kept on wake", SYS_CONTROL_TWO_OFS, 32'h4);
      rdchk("sleep bit cleared", SYS_CONTROL_ONE_OFS, 32'h0);
      rdchk("wake inhibit", STATUS_OFS,
         (1 << STATUS_INHIBIT_BIT) | (1 << (STATUS_CAUSE_LSB + CAUSE_SLEEP)));
      wait_rst();
      wr(PORT_RESET_SLEEP_OPTION_OFS, 32'h1);
      wr(PORT_RESET_SELECT_B_OFS, 32'hf);
      wr(SYS_CONTROL_ONE_OFS, 32'h1);
      tick(3);
      chk("port kept on in sleep", pa_en, 1);
      i_far.set_port(4'hf);
      // well inside the debounce time, so only the undebounced path can wake
      tick(DEB / 4);
      chk("port wake", mode, MODE_ACTIVE);
      i_far.set_port(4'h0);
      wr(PORT_RESET_SELECT_B_OFS, 32'h0);
      wait_rst();
      osc_stop <= 1'b1;
      tick(6);
      chk("oscillation loss reset", sys_rst, 1);
      osc_stop <= 1'b0;
      wait_rst();
      wr(LEVEL_DETECT_CONTROL_OFS, 32'h1);
      osc_stop <= 1'b1;
      tick(10);
      chk("loss guard off", sys_rst, 0);
      osc_stop <= 1'b0;
      wdog <= 1'b1;
      tick(1);
      wdog <= 1'b0;
      tick(2);
      chk("watchdog reset", sys_rst, 1);
      rdchk("guard back on", LEVEL_DETECT_CONTROL_OFS, 32'h0);
      rdchk("arm kept on reset", SYS_CONTROL_TWO_OFS, 32'h4);
      wait_rst();
      i_far.pulse_pin(DEB - 5);
      tick(5);
      chk("short pin pulse", sys_rst, 0);
      i_far.pulse_pin(DEB + 5);
      tick(1);
      chk("debounced pin reset", sys_rst, 1);
      wait_rst();
      wr(DISPLAY_CONTROL_ONE_OFS, 32'h1);
      strobe_alt <= 1'b1;
      tick(2);
      chk("strobe from other source", strobe, 1);
      srst_in <= 1'b1;
      tick(2);
      srst_in <= 1'b0;
      wait_rst();
      rdchk("arm cleared by power-on", SYS_CONTROL_TWO_OFS, 32'h0);
      stop_test();
   end
endmodule

// *** tb/mode_reset_chk.sv ***
`timescale 1ns/100ps
module mode_reset_chk
   import mode_reset_pkg::*;
#(
   parameter int CPU_DELAY = 40,
   parameter int SYS_DELAY = 4
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic srst_in,
   // watched ports
   input wire logic halt_in,
   input wire logic irq_pending_in,
   input wire logic watchdog_reset_in,
   input wire logic reset_pin_in,
   input wire logic cpu_clock_enable_out,
   input wire logic cpu_reset_out,
   input wire logic sys_reset_out,
   input wire logic osc_enable_out,
   input wire logic periph_clock_enable_out,
   input wire logic level_detect_enable_out,
   input wire logic port_b_hiz_out,
   input wire logic serial_hiz_out,
   input wire logic buzzer_hiz_out,
   input wire logic input_port_enable_out,
   input wire logic [1:0] mode_out
);
   logic [15:0] cpu_cnt_r;
   logic [15:0] sys_cnt_r;

   default clocking @(posedge clock_in); endclocking
   default disable iff (srst_in);

   // run lengths of the resets; power-on pins them to 1 so no unknown lingers
   always_ff @(posedge clock_in) begin
      cpu_cnt_r <= srst_in ? 16'h1 : (cpu_reset_out ? cpu_cnt_r + 16'h1 : 16'h0);
   end
   always_ff @(posedge clock_in) begin
      sys_cnt_r <= srst_in ? 16'h1 : (sys_reset_out ? sys_cnt_r + 16'h1 : 16'h0);
   end

   AST_HALT: assert property (
      mode_out == MODE_ACTIVE && halt_in && !cpu_reset_out && !irq_pending_in
      && !watchdog_reset_in |=> mode_out == MODE_STANDBY) else $error("halt missed standby");
   AST_CPU_CLOCK: assert property (
      cpu_clock_enable_out == (mode_out == MODE_ACTIVE && !cpu_reset_out))
      else $error("cpu clock enable wrong");
   AST_IRQ_WAKE: assert property (
      mode_out == MODE_STANDBY && irq_pending_in |=> mode_out == MODE_ACTIVE)
      else $error("interrupt did not end standby");
   // sync plus filter: the pin must have stood high a few cycles back
   AST_WAKE_CAUSE: assert property (
      $past(mode_out) == MODE_SLEEP && mode_out != MODE_SLEEP |-> $past(input_port_enable_out)
      || ($past(reset_pin_in, 4) && $past(reset_pin_in, 6))) else $error("wake without cause");
   AST_SLEEP_OSC: assert property (
      mode_out == MODE_SLEEP ##1 mode_out == MODE_SLEEP |-> !osc_enable_out
      && !periph_clock_enable_out) else $error("oscillator running in sleep");
   AST_SLEEP_PINS: assert property (
      mode_out == MODE_SLEEP ##1 mode_out == MODE_SLEEP |-> port_b_hiz_out && serial_hiz_out
      && buzzer_hiz_out) else $error("pins driven in sleep");
   AST_LEVEL_SLEEP: assert property (
      mode_out == MODE_SLEEP ##1 mode_out == MODE_SLEEP |-> !level_detect_enable_out)
      else $error("level detector on in sleep");
   AST_CPU_COVERS_SYS: assert property (
      sys_reset_out |-> cpu_reset_out) else $error("system reset without cpu reset");
   AST_CPU_LENGTH: assert property (
      $fell(cpu_reset_out) |-> cpu_cnt_r >= CPU_DELAY) else $error("cpu reset too short");
   AST_SYS_LENGTH: assert property (
      $fell(sys_reset_out) |-> sys_cnt_r >= SYS_DELAY) else $error("system reset too short");
   AST_SLEEP_RESET: assert property (
      mode_out == MODE_SLEEP ##1 mode_out == MODE_SLEEP |-> sys_reset_out && cpu_reset_out)
      else $error("reset not held in sleep");

   cover property (mode_out == MODE_SLEEP ##1 mode_out == MODE_ACTIVE);
   cover property (mode_out == MODE_STANDBY ##1 mode_out == MODE_ACTIVE);
   cover property ($fell(cpu_reset_out));
endmodule

bind mode_and_reset_control mode_reset_chk #(.CPU_DELAY(CPU_DELAY), .SYS_DELAY(SYS_DELAY))
   i_chk (
   .clock_in(clock_in), .srst_in(srst_in), .halt_in(halt_in),
   .irq_pending_in(irq_pending_in), .watchdog_reset_in(watchdog_reset_in),
   .reset_pin_in(reset_pin_in), .cpu_clock_enable_out(cpu_clock_enable_out),
   .cpu_reset_out(cpu_reset_out), .sys_reset_out(sys_reset_out),
   .osc_enable_out(osc_enable_out), .periph_clock_enable_out(periph_clock_enable_out),
   .level_detect_enable_out(level_detect_enable_out), .port_b_hiz_out(port_b_hiz_out),
   .serial_hiz_out(serial_hiz_out), .buzzer_hiz_out(buzzer_hiz_out),
   .input_port_enable_out(input_port_enable_out), .mode_out(mode_out)
);

// *** tb/pin_side_model.sv ***
`timescale 1ns/100ps
module pin_side_model (
   // clock
   input wire logic clock_in,
   // pins toward the device
   output logic reset_pin_out,
   output logic [3:0] input_port_pin_out
);
   // reset pin has a pull-down, so released means low
   initial begin
      reset_pin_out = 1'b0;
      input_port_pin_out = 4'h0;
   end

   // holds the pin high for exactly n sampled edges
   task automatic pulse_pin(input int n);
      @(posedge clock_in);
      reset_pin_out <= 1'b1;
      repeat (n) @(posedge clock_in);
      reset_pin_out <= 1'b0;
   endtask

   task automatic set_port(input logic [3:0] v);
      @(posedge clock_in);
      input_port_pin_out <= v;
   endtask
endmodule
